// *** mam_defs.svh ***
// Alarm codes, blink counts and lamp timing
`ifndef MAM_DEFS_SVH
`define MAM_DEFS_SVH
`define MAM_CODE_NONE 8'h00
`define MAM_CODE_POS_RANGE 8'h32
`define MAM_CODE_STACK 8'h90
`define MAM_CODE_SEQ_REF 8'h94
`define MAM_CODE_CALC_OVF 8'h98
`define MAM_CODE_PARAM_RANGE 8'h99
`define MAM_CODE_ZERO_DIV 8'h9A
`define MAM_CODE_PC_WRITE 8'h9D
`define MAM_CODE_VAR_REF 8'h9E
`define MAM_CODE_PARAM_WRITE 8'h9F
`define MAM_CODE_MOTION_BUSY 8'hA0
`define MAM_CODE_USER 8'hE0
`define MAM_CODE_PANIC 8'h68
`define MAM_CODE_LS_LOGIC 8'h60
`define MAM_CODE_LS_REVERSE 8'h61
`define MAM_CODE_HOME_FAIL 8'h62
`define MAM_CODE_HOME_MISSING 8'h63
`define MAM_CODE_TIM_SENSOR 8'h64
`define MAM_CODE_HW_OVERTRAVEL 8'h66
`define MAM_CODE_SW_OVERTRAVEL 8'h67
`define MAM_CODE_LS_OFFSET 8'h6A
`define MAM_CODE_DRV_ALARM 8'h6E
`define MAM_CODE_DRV_CONN 8'h6F
`define MAM_CODE_MOTION_PARAM 8'h70
`define MAM_CODE_NVM 8'h41
`define MAM_CODE_SYS 8'hF0
`define MAM_CODE_MEM 8'hF1
`define MAM_CODE_SEQ_INT 8'hF2
`define MAM_BLINK_ONE 4'h1
`define MAM_BLINK_SIX 4'h6
`define MAM_BLINK_SEVEN 4'h7
`define MAM_BLINK_NINE 4'h9
`define MAM_BLINK_STEADY 4'h0
`define MAM_CLK_HZ 20000000
`define MAM_BLINK_ON_MS 200
`define MAM_BLINK_OFF_MS 200
`define MAM_PAUSE_MS 1200
`define MAM_MS_CYCLES(ms) ((ms) * (`MAM_CLK_HZ / 1000))
`define MAM_SRC_COUNT 27
`define MAM_TMR_W 25
`endif

// *** mam_pkg.sv ***
// Types shared by the motion alarm manager
package mam_pkg;
    typedef enum logic [1:0] {
        MAM_ACT_NONE,
        MAM_ACT_STOP,
        MAM_ACT_SELECT,
        MAM_ACT_CURRENT_OFF
    } mam_action_t;
    typedef enum logic [1:0] {
        MAM_SEL_STOP,
        MAM_SEL_CURRENT_OFF,
        MAM_SEL_NONE,
        MAM_SEL_RSVD
    } mam_select_t;
endpackage : mam_pkg

// *** mam_blinker.sv ***
// Blink-group generator for the alarm indicator
`timescale 1ns/1ps
`include "mam_defs.svh"
module mam_blinker
    import mam_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pattern request
    input wire logic active,
    input wire logic [3:0] blink_count,
    // Indicator
    output logic lamp
);
    typedef enum {MAM_B_IDLE, MAM_B_ON, MAM_B_OFF, MAM_B_PAUSE} mam_bstate_t;
    localparam logic [`MAM_TMR_W-1:0] ON_CYC = `MAM_TMR_W'(`MAM_MS_CYCLES(`MAM_BLINK_ON_MS));
    localparam logic [`MAM_TMR_W-1:0] OFF_CYC = `MAM_TMR_W'(`MAM_MS_CYCLES(`MAM_BLINK_OFF_MS));
    localparam logic [`MAM_TMR_W-1:0] PAUSE_CYC = `MAM_TMR_W'(`MAM_MS_CYCLES(`MAM_PAUSE_MS));
    mam_bstate_t state;
    logic [`MAM_TMR_W-1:0] timer;
    logic [3:0] done;
    logic expired;
    assign expired = (timer == `MAM_TMR_W'(1));
    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state <= MAM_B_IDLE;
            timer <= '0;
            done <= 4'h0;
            lamp <= 1'b0;
        end
        else if (!active || blink_count == `MAM_BLINK_STEADY)
        begin
            // Internal faults (steady code) hold the lamp lit; no alarm keeps it dark
            state <= MAM_B_IDLE;
            done <= 4'h0;
            lamp <= active;
        end
        else
        begin
            unique case (state)
                MAM_B_IDLE:
                begin
                    state <= MAM_B_ON;
                    timer <= ON_CYC;
                    lamp <= 1'b1;
                end
                MAM_B_ON:
                begin
                    if (expired)
                    begin
                        lamp <= 1'b0;
                        if (done + 4'h1 >= blink_count)
                        begin
                            state <= MAM_B_PAUSE;
                            timer <= PAUSE_CYC;
                            done <= 4'h0;
                        end
                        else
                        begin
                            state <= MAM_B_OFF;
                            timer <= OFF_CYC;
                            done <= done + 4'h1;
                        end
                    end
                    else
                        timer <= timer - `MAM_TMR_W'(1);
                end
                MAM_B_OFF, MAM_B_PAUSE:
                begin
                    if (expired)
                    begin
                        state <= MAM_B_ON;
                        timer <= ON_CYC;
                        lamp <= 1'b1;
                    end
                    else
                        timer <= timer - `MAM_TMR_W'(1);
                end
            endcase
        end
    end
endmodule : mam_blinker

// *** mam_manager.sv ***
// Alarm latch, action decode and outputs of the motion alarm manager
//
// Behaviour
// - Any alarm sets an assigned alarm output active; all but 0xF0/0xF1/0xF2 blink the indicator.
// - Position beyond signed 32-bit range: 0x32, one blink, stop, clearable.
// - Stack exhausted 0x90, missing subroutine 0x94: one blink, stop, clearable.
// - Overflow 0x98, divide by zero 0x9A: one blink, stop, clearable.
// - Position counter write while moving: 0x9D, one blink, stop.
// - Undefined variable 0x9E, barred parameter write 0x9F: one blink, stop, clearable.
// - Incompatible motion start while moving: 0xA0, one blink, stop.
// - User alarm raise latches 0xE0, one blink, stop, clearable.
// - Panic stop: 0x68, six blinks, action from alarm action select.
// - Both limit switches active: 0x60, seven blinks, stop.
// - Limit opposite seek direction while homing: 0x61, stop.
// - Unstable limit while homing 0x62; home never seen 0x63; both stop.
// - Timing or sensor input missing at home: 0x64, stop.
// - Hardware over-travel 0x66, soft limit 0x67; action from alarm action select.
// - Limit during homing offset move: 0x6A, stop.
// - Driver alarm 0x6E, driver no response 0x6F: stop.
// - Incompatible motion parameters: 0x70, stop.
// - Corrupt nonvolatile data: 0x41, nine blinks, current off, clear ignored.
// - Internal faults 0xF0/0xF1/0xF2 hold indicator on, current off, clear ignored.
// - Clear command clears clearable alarms only; system reset always clears.
// - Alarm query returns the currently latched code.
// - Out-of-range parameter set: 0x99, one blink, stop.
`timescale 1ns/1ps
`include "mam_defs.svh"
module mam_manager
    import mam_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Condition pulses from motion and sequence engines
    input wire logic position_out_of_range,
    input wire logic stack_overflow,
    input wire logic sequence_missing,
    input wire logic calc_overflow,
    input wire logic param_out_of_range,
    input wire logic zero_division,
    input wire logic position_counter_busy_write,
    input wire logic variable_missing,
    input wire logic param_write_prohibited,
    input wire logic motion_while_moving,
    input wire logic user_alarm_raise,
    input wire logic panic_stop_input,
    input wire logic panic_stop_command,
    input wire logic limit_switch_pos,
    input wire logic limit_switch_neg,
    input wire logic home_seeking,
    input wire logic home_seek_positive,
    input wire logic home_limit_unstable,
    input wire logic home_not_found,
    input wire logic timing_position_signal_missing,
    input wire logic soft_limit_exceeded,
    input wire logic home_offset_moving,
    input wire logic driver_alarm,
    input wire logic driver_no_response,
    input wire logic motion_param_error,
    input wire logic nvm_corrupt,
    input wire logic internal_state_error,
    input wire logic memory_access_error,
    input wire logic sequence_code_invalid,
    // Host commands and settings
    input wire logic alarm_clear_command,
    input wire logic system_reset_command,
    input wire logic alarm_code_query,
    input wire logic [1:0] alarm_action_select,
    input wire logic alarm_output_assigned,
    input wire logic alarm_output_active_level,
    // Status and actions
    output logic [7:0] alarm_code,
    output logic query_valid,
    output logic [7:0] query_code,
    output logic alarm_indicator,
    output logic alarm_output,
    output logic stop_motion,
    output logic disable_current
);
    ////////////////////////////////////////////////////////////////////////////
    // Condition table, lowest index wins; fatal ones first
    logic [`MAM_SRC_COUNT-1:0] hit;
    logic [7:0] src_code [`MAM_SRC_COUNT];
    logic [3:0] src_blink [`MAM_SRC_COUNT];
    mam_action_t src_act [`MAM_SRC_COUNT];
    logic any_limit;
    logic opposite_limit;
    assign any_limit = limit_switch_pos | limit_switch_neg;
    assign opposite_limit = home_seek_positive ? limit_switch_neg
                                               : limit_switch_pos;

    always_comb
    begin
        hit[0] = internal_state_error;
        src_code[0] = `MAM_CODE_SYS;
        hit[1] = memory_access_error;
        src_code[1] = `MAM_CODE_MEM;
        hit[2] = sequence_code_invalid;
        src_code[2] = `MAM_CODE_SEQ_INT;
        hit[3] = nvm_corrupt;
        src_code[3] = `MAM_CODE_NVM;
        hit[4] = panic_stop_input | panic_stop_command;
        src_code[4] = `MAM_CODE_PANIC;
        hit[5] = limit_switch_pos & limit_switch_neg;
        src_code[5] = `MAM_CODE_LS_LOGIC;
        hit[6] = home_seeking & opposite_limit;
        src_code[6] = `MAM_CODE_LS_REVERSE;
        hit[7] = home_seeking & home_limit_unstable;
        src_code[7] = `MAM_CODE_HOME_FAIL;
        hit[8] = home_seeking & home_not_found;
        src_code[8] = `MAM_CODE_HOME_MISSING;
        hit[9] = home_seeking & timing_position_signal_missing;
        src_code[9] = `MAM_CODE_TIM_SENSOR;
        hit[10] = home_offset_moving & any_limit;
        src_code[10] = `MAM_CODE_LS_OFFSET;
        // Homing handles its own limits, so over-travel is masked then
        hit[11] = any_limit & ~home_seeking & ~home_offset_moving;
        src_code[11] = `MAM_CODE_HW_OVERTRAVEL;
        hit[12] = soft_limit_exceeded;
        src_code[12] = `MAM_CODE_SW_OVERTRAVEL;
        hit[13] = driver_alarm;
        src_code[13] = `MAM_CODE_DRV_ALARM;
        hit[14] = driver_no_response;
        src_code[14] = `MAM_CODE_DRV_CONN;
        hit[15] = motion_param_error;
        src_code[15] = `MAM_CODE_MOTION_PARAM;
        hit[16] = position_out_of_range;
        src_code[16] = `MAM_CODE_POS_RANGE;
        hit[17] = stack_overflow;
        src_code[17] = `MAM_CODE_STACK;
        hit[18] = sequence_missing;
        src_code[18] = `MAM_CODE_SEQ_REF;
        hit[19] = calc_overflow;
        src_code[19] = `MAM_CODE_CALC_OVF;
        hit[20] = param_out_of_range;
        src_code[20] = `MAM_CODE_PARAM_RANGE;
        hit[21] = zero_division;
        src_code[21] = `MAM_CODE_ZERO_DIV;
        hit[22] = position_counter_busy_write;
        src_code[22] = `MAM_CODE_PC_WRITE;
        hit[23] = variable_missing;
        src_code[23] = `MAM_CODE_VAR_REF;
        hit[24] = param_write_prohibited;
        src_code[24] = `MAM_CODE_PARAM_WRITE;
        hit[25] = motion_while_moving;
        src_code[25] = `MAM_CODE_MOTION_BUSY;
        hit[26] = user_alarm_raise;
        src_code[26] = `MAM_CODE_USER;
    end

    genvar gi;
    generate
        for (gi = 0; gi < `MAM_SRC_COUNT; gi++)
        begin : g_src
            assign src_blink[gi] = (gi < 3) ? `MAM_BLINK_STEADY :
                                   (gi == 3) ? `MAM_BLINK_NINE :
                                   (gi == 4) ? `MAM_BLINK_SIX :
                                   (gi < 16) ? `MAM_BLINK_SEVEN : `MAM_BLINK_ONE;
            assign src_act[gi] = (gi < 4) ? MAM_ACT_CURRENT_OFF :
                                 (gi == 4 || gi == 11 || gi == 12) ? MAM_ACT_SELECT :
                                 MAM_ACT_STOP;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Priority pick
    logic any_hit;
    logic [7:0] pick_code;
    logic [3:0] pick_blink;
    mam_action_t pick_act;
    always_comb
    begin
        any_hit = 1'b0;
        pick_code = `MAM_CODE_NONE;
        pick_blink = `MAM_BLINK_ONE;
        pick_act = MAM_ACT_NONE;
        for (int i = `MAM_SRC_COUNT - 1; i >= 0; i--)
        begin
            if (hit[i])
            begin
                any_hit = 1'b1;
                pick_code = src_code[i];
                pick_blink = src_blink[i];
                pick_act = src_act[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Latch: first alarm holds until cleared
    logic latched;
    logic [3:0] blink_count;
    mam_action_t action;
    logic clearable;
    logic do_clear;
    assign clearable = (action != MAM_ACT_CURRENT_OFF);
    // Event in the clear cycle stays latched
    assign do_clear = system_reset_command
                      | (alarm_clear_command & clearable);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            latched <= 1'b0;
            alarm_code <= `MAM_CODE_NONE;
            blink_count <= `MAM_BLINK_ONE;
            action <= MAM_ACT_NONE;
        end
        else if (any_hit && (!latched || do_clear))
        begin
            latched <= 1'b1;
            alarm_code <= pick_code;
            blink_count <= pick_blink;
            action <= pick_act;
        end
        else if (latched && do_clear)
        begin
            latched <= 1'b0;
            alarm_code <= `MAM_CODE_NONE;
            blink_count <= `MAM_BLINK_ONE;
            action <= MAM_ACT_NONE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Query answer
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            query_valid <= 1'b0;
            query_code <= `MAM_CODE_NONE;
        end
        else
        begin
            query_valid <= alarm_code_query;
            if (alarm_code_query)
                query_code <= alarm_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // System action; selectable action tracks the setting live
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stop_motion <= 1'b0;
            disable_current <= 1'b0;
        end
        else
        begin
            unique case (action)
                MAM_ACT_NONE:
                begin
                    stop_motion <= 1'b0;
                    disable_current <= 1'b0;
                end
                MAM_ACT_STOP:
                begin
                    stop_motion <= 1'b1;
                    disable_current <= 1'b0;
                end
                MAM_ACT_SELECT:
                begin
                    stop_motion <= (alarm_action_select != MAM_SEL_NONE);
                    disable_current <= (alarm_action_select == MAM_SEL_CURRENT_OFF);
                end
                MAM_ACT_CURRENT_OFF:
                begin
                    stop_motion <= 1'b1;
                    disable_current <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Alarm output: low in reset, then inactive level while unassigned or idle
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            alarm_output <= 1'b0;
        else if (alarm_output_assigned && latched)
            alarm_output <= alarm_output_active_level;
        else
            alarm_output <= ~alarm_output_active_level;
    end

    mam_blinker u_blinker (
        .clk(clk),
        .rst_b(rst_b),
        .active(latched),
        .blink_count(blink_count),
        .lamp(alarm_indicator)
    );
endmodule : mam_manager

// *** mam_host_model.sv ***
// Host and engine model: raises alarm conditions and issues clears
`timescale 1ns/1ps
module mam_host_model #(
    parameter int DECEL_CYCLES = 6
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Bench requests
    input wire logic fire,
    input wire logic [25:0] pattern,
    input wire logic clr_req,
    input wire logic rst_req,
    // Toward the alarm manager
    output logic [25:0] cond,
    output logic alarm_clear_command,
    output logic system_reset_command
);
    int wait_cnt;

    ////////////////////////////////////////////////////////////////////////////
    // One-cycle condition per request
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            cond <= '0;
        else
            cond <= fire ? pattern : '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear waits out the deceleration time, else the motor may restart
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wait_cnt <= 0;
            alarm_clear_command <= 1'h0;
        end
        else
        begin
            alarm_clear_command <= (wait_cnt == 1);
            if (clr_req)
                wait_cnt <= DECEL_CYCLES;
            else if (wait_cnt != 0)
                wait_cnt <= wait_cnt - 1;
        end
    end

    // System reset, the host's other choice
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            system_reset_command <= 1'h0;
        else
            system_reset_command <= rst_req;
    end
endmodule : mam_host_model

// *** mam_manager_properties.sv ***
// Concurrent checks on the alarm manager ports
`timescale 1ns/1ps
module mam_manager_props (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Commands and settings
    input wire logic alarm_clear_command,
    input wire logic system_reset_command,
    input wire logic alarm_code_query,
    input wire logic user_alarm_raise,
    input wire logic [1:0] alarm_action_select,
    input wire logic alarm_output_assigned,
    input wire logic alarm_output_active_level,
    // Status and actions
    input wire logic [7:0] alarm_code,
    input wire logic query_valid,
    input wire logic [7:0] query_code,
    input wire logic alarm_indicator,
    input wire logic alarm_output,
    input wire logic stop_motion,
    input wire logic disable_current
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    a_code_hold: assert property (
        (alarm_code != 8'h00 && !alarm_clear_command && !system_reset_command)
        |=> alarm_code == $past(alarm_code)) else $error("latched code moved");
    a_fatal_keep: assert property (
        (alarm_code inside {8'h41, 8'hF0, 8'hF1, 8'hF2} && !system_reset_command)
        |=> $stable(alarm_code)) else $error("fatal code cleared");
    a_clear_user: assert property (
        (alarm_clear_command && alarm_code == 8'hE0 && !user_alarm_raise)
        |=> alarm_code == 8'h00) else $error("user alarm kept");
    a_query_reply: assert property (
        alarm_code_query |=> query_valid && query_code == $past(alarm_code))
        else $error("query reply wrong");
    a_query_quiet: assert property (
        !alarm_code_query |=> !query_valid) else $error("query valid unasked");
    a_idle_quiet: assert property (
        (alarm_code == 8'h00) [*2] |-> !stop_motion && !disable_current)
        else $error("action without alarm");
    a_idle_output: assert property (
        (alarm_code == 8'h00) [*2] ##0 $stable(alarm_output_active_level)
        |-> alarm_output == !alarm_output_active_level) else $error("output active idle");
    a_lamp_dark: assert property (
        (alarm_code == 8'h00) [*3] |-> !alarm_indicator) else $error("lamp lit idle");
    a_output_set: assert property (
        (alarm_code != 8'h00) [*2] ##0 (alarm_output_assigned && $stable(alarm_output_assigned)
        && $stable(alarm_output_active_level)) |-> alarm_output == alarm_output_active_level)
        else $error("output inactive");
    a_user_stop: assert property (
        (alarm_code == 8'hE0) [*2] |-> stop_motion && !disable_current)
        else $error("user action wrong");
    a_nvm_cut: assert property (
        (alarm_code == 8'h41) [*2] |-> disable_current) else $error("current kept");
    a_lamp_steady: assert property (
        (alarm_code == 8'hF0) [*3] |-> alarm_indicator) else $error("lamp not steady");
    a_panic_select: assert property (
        (alarm_code == 8'h68 && $past(alarm_code) == 8'h68)
        |-> stop_motion == ($past(alarm_action_select) != 2'h2)
        && disable_current == ($past(alarm_action_select) == 2'h1))
        else $error("panic action wrong");

    c_user_clear: cover property (alarm_code == 8'hE0 ##1 alarm_code == 8'h00);
    c_fatal: cover property (alarm_code == 8'hF0);
    c_query: cover property (query_valid && query_code != 8'h00);
endmodule : mam_manager_props

bind mam_manager mam_manager_props u_props (.*);

// *** mam_manager_test.sv ***
// Self-checking bench for the motion alarm manager
`timescale 1ns/1ps
module mam_manager_test;
    typedef struct packed {logic [4:0] idx; logic [2:0] mode; logic [7:0] code;} mam_row_t;
    // Mode is {home_seeking, home_seek_positive, home_offset_moving}
    localparam mam_row_t ROWS [29] = '{
        '{5'h00, 3'h0, 8'h32}, '{5'h01, 3'h0, 8'h90}, '{5'h02, 3'h0, 8'h94}, '{5'h03, 3'h0, 8'h98},
        '{5'h04, 3'h0, 8'h99}, '{5'h05, 3'h0, 8'h9A}, '{5'h06, 3'h0, 8'h9D}, '{5'h07, 3'h0, 8'h9E},
        '{5'h08, 3'h0, 8'h9F}, '{5'h09, 3'h0, 8'hA0}, '{5'h0A, 3'h0, 8'hE0}, '{5'h0B, 3'h0, 8'h68},
        '{5'h0C, 3'h0, 8'h68}, '{5'h0D, 3'h0, 8'h66}, '{5'h0E, 3'h0, 8'h66}, '{5'h0D, 3'h4, 8'h61},
        '{5'h0E, 3'h6, 8'h61}, '{5'h0F, 3'h6, 8'h62}, '{5'h10, 3'h6, 8'h63}, '{5'h11, 3'h6, 8'h64},
        '{5'h0D, 3'h1, 8'h6A}, '{5'h12, 3'h0, 8'h67}, '{5'h13, 3'h0, 8'h6E}, '{5'h14, 3'h0, 8'h6F},
        '{5'h15, 3'h0, 8'h70}, '{5'h16, 3'h0, 8'h41}, '{5'h17, 3'h0, 8'hF0},
        '{5'h18, 3'h0, 8'hF1}, '{5'h19, 3'h0, 8'hF2}};
    localparam int DECEL = 6;
    logic clk, rst_b, fire, clr_req, rst_req, query, seeking, seek_pos, offset_mv, level, assigned;
    logic clr_cmd, sys_rst, query_valid, lamp, alarm_output, stop_motion, disable_current;
    logic [1:0] act_sel;
    logic [25:0] pattern, cond;
    logic [7:0] alarm_code, query_code;
    int n_mismatch = 0;
    int num_checks = 0;
    int cycles = 0;

    mam_host_model #(.DECEL_CYCLES(DECEL)) host (.clk(clk), .rst_b(rst_b), .fire(fire),
        .pattern(pattern), .clr_req(clr_req), .rst_req(rst_req), .cond(cond),
        .alarm_clear_command(clr_cmd), .system_reset_command(sys_rst));

    mam_manager DUT (.clk(clk), .rst_b(rst_b), .position_out_of_range(cond[0]),
        .stack_overflow(cond[1]), .sequence_missing(cond[2]), .calc_overflow(cond[3]),
        .param_out_of_range(cond[4]), .zero_division(cond[5]),
        .position_counter_busy_write(cond[6]), .variable_missing(cond[7]),
        .param_write_prohibited(cond[8]), .motion_while_moving(cond[9]),
        .user_alarm_raise(cond[10]), .panic_stop_input(cond[11]), .panic_stop_command(cond[12]),
        .limit_switch_pos(cond[13]), .limit_switch_neg(cond[14]), .home_seeking(seeking),
        .home_seek_positive(seek_pos), .home_limit_unstable(cond[15]),
        .home_not_found(cond[16]), .timing_position_signal_missing(cond[17]),
        .soft_limit_exceeded(cond[18]), .home_offset_moving(offset_mv),
        .driver_alarm(cond[19]), .driver_no_response(cond[20]), .motion_param_error(cond[21]),
        .nvm_corrupt(cond[22]), .internal_state_error(cond[23]),
        .memory_access_error(cond[24]), .sequence_code_invalid(cond[25]),
        .alarm_clear_command(clr_cmd), .system_reset_command(sys_rst), .alarm_code_query(query),
        .alarm_action_select(act_sel), .alarm_output_assigned(assigned),
        .alarm_output_active_level(level), .alarm_code(alarm_code), .query_valid(query_valid),
        .query_code(query_code), .alarm_indicator(lamp), .alarm_output(alarm_output),
        .stop_motion(stop_motion), .disable_current(disable_current));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        num_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // Bounded wait, so a silent design cannot hang here
    task automatic hit(input logic [25:0] mask);
        int k = 0;
        @(posedge clk);
        pattern <= mask;
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        @(negedge clk);
        while (alarm_code === 8'h00 && k < 10)
        begin
            @(negedge clk);
            k++;
        end
        repeat (3) @(negedge clk);
    endtask : hit

    task automatic pulse(input logic reset_it);
        @(posedge clk);
        {rst_req, clr_req} <= {reset_it, !reset_it};
        @(posedge clk);
        {rst_req, clr_req} <= 2'h0;
        repeat (DECEL + 4) @(negedge clk);
    endtask : pulse

    task automatic run_row(input mam_row_t r);
        logic fatal = (r.code == 8'h41) || (r.code[7:4] == 4'hF);
        @(posedge clk);
        {seeking, seek_pos, offset_mv} <= r.mode;
        hit(26'h1 << r.idx);
        chk8("code", r.code, alarm_code);
        chk1("lamp", 1'h1, lamp);
        chk1("output", level, alarm_output);
        chk1("current", fatal, disable_current);
        if (!fatal)
            chk1("stop", 1'h1, stop_motion);
        @(posedge clk);
        query <= 1'h1;
        @(posedge clk);
        query <= 1'h0;
        @(negedge clk);
        chk1("query valid", 1'h1, query_valid);
        chk8("query code", r.code, query_code);
        pulse(1'h0);
        chk8("after clear", fatal ? r.code : 8'h00, alarm_code);
        if (fatal)
            pulse(1'h1);
        chk8("after reset", 8'h00, alarm_code);
        chk1("lamp idle", 1'h0, lamp);
        chk1("stop idle", 1'h0, stop_motion);
        {seeking, seek_pos, offset_mv} <= 3'h0;
        $display("test row %h done", r.code);
    endtask : run_row

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial
    begin
        {rst_b, fire, clr_req, rst_req, query, seeking, seek_pos, offset_mv, pattern} = '0;
        {level, assigned, act_sel} = 4'hC;
        repeat (4) @(posedge clk);
        rst_b <= 1'h1;
        repeat (2) @(negedge clk);
        chk1("output idle", 1'h0, alarm_output);
        foreach (ROWS[i])
            run_row(ROWS[i]);
        // Simultaneous hits: the lower table index (fatal first, then both limits) must win
        hit(26'h0800400);
        chk8("priority", 8'hF0, alarm_code);
        pulse(1'h1);
        hit(26'h0006000);
        chk8("both limits", 8'h60, alarm_code);
        pulse(1'h1);
        // A later hit must not replace a latched code
        hit(26'h0000400);
        hit(26'h0000001);
        chk8("first wins", 8'hE0, alarm_code);
        pulse(1'h1);
        $display("test priority done");
        // Panic action follows the setting live
        hit(26'h0000800);
        for (int s = 0; s < 4; s++)
        begin
            @(posedge clk);
            act_sel <= s[1:0];
            repeat (3) @(negedge clk);
            chk1("panic stop", s != 2, stop_motion);
            chk1("panic current", s == 1, disable_current);
        end
        act_sel <= 2'h0;
        assigned <= 1'h0;
        pulse(1'h0);
        $display("test select done");
        // Mid-run async reset drops everything
        hit(26'h0000400);
        chk1("unassigned", 1'h0, alarm_output);
        @(posedge clk);
        rst_b <= 1'h0;
        @(negedge clk);
        chk8("code in reset", 8'h00, alarm_code);
        chk1("stop in reset", 1'h0, stop_motion);
        @(posedge clk);
        rst_b <= 1'h1;
        repeat (3) @(negedge clk);
        chk1("output after reset", 1'h0, alarm_output);
        $display("test reset done");
        give_verdict();
    end
endmodule : mam_manager_test
